// ### sleep_port_clock_gate.v
// Sleep-mode port clock gating register with AXI4-Lite slave and fault detection
//
// Function
// [RULE1] A port is clocked while its selected gate bit is 1 and unclocked while it is 0.
// [RULE2] A bus access to a port whose clock is gated off is answered with a bus fault.
// [RULE3] The sleep gate register resets to all zeros, leaving every port unclocked; the code does so only in Sleep with auto clock gating on.
// [RULE4] Bit 7 gates port H down through bit 0 gating port A.
// [RULE5] Bits 31 to 8 are read-only zero; software preserves them in read-modify-write.
// [RULE6] This register gates ports only in Sleep; run and deep-sleep use their own registers.
// [RULE7] Sleep gating from this register applies only when auto clock gating is enabled.
// [RULE8] Software enables each needed port itself; hardware enables none on its own.
// [RULE9] With auto clock gating clear, Sleep keeps the run-mode enables and ignores this one.
`timescale 1ns/100ps
module sleep_port_clock_gate (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Mode and sibling gating registers
  input  wire [1:0]  power_mode,
  input  wire        auto_clock_gating_enable,
  input  wire [7:0]  run_port_clock_gate,
  input  wire [7:0]  deep_sleep_port_clock_gate,
  // Port clock enables, bit 0 port A to bit 7 port H
  output reg  [7:0]  port_clk_en,
  // Port access fault check
  input  wire        port_acc_valid,
  input  wire [2:0]  port_acc_sel,
  output reg         port_bus_fault
);
`include "sleep_gate_map.vh"

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg  [7:0]  gate_ff;
  reg  [11:0] waddr_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg         have_aw_ff;
  reg         have_w_ff;
  wire [7:0]  port_en;
  wire        acc_fault;

  // Full-width copies of the map constants so every slice below is explicit
  localparam [31:0] GATE_RST   = `SPCG_RESET;
  localparam [31:0] GATE_WMASK = `SPCG_WMASK;
  localparam [11:0] GATE_ADDR  = `SPCG_OFFSET;
  localparam [11:0] STAT_ADDR  = `SPCG_STAT_OFFSET;

  // Named port bits of the gate register
  wire        port_a_gate = gate_ff[0]; // [RULE4]
  wire        port_b_gate = gate_ff[1];
  wire        port_c_gate = gate_ff[2];
  wire        port_d_gate = gate_ff[3];
  wire        port_e_gate = gate_ff[4];
  wire        port_f_gate = gate_ff[5];
  wire        port_g_gate = gate_ff[6];
  wire        port_h_gate = gate_ff[7];
  wire [7:0]  sleep_port_clock_gate = {port_h_gate, port_g_gate, port_f_gate, port_e_gate,
                                       port_d_gate, port_c_gate, port_b_gate, port_a_gate};

  // --------------------------------------------------------------------------
  // Enable selection and fault detection
  // --------------------------------------------------------------------------
  port_gate_sel u_sel (
    .power_mode                 (power_mode),
    .auto_clock_gating_enable   (auto_clock_gating_enable),
    .run_port_clock_gate        (run_port_clock_gate),
    .sleep_port_clock_gate      (sleep_port_clock_gate),
    .deep_sleep_port_clock_gate (deep_sleep_port_clock_gate),
    .port_en                    (port_en)
  );

  port_fault_chk u_fault (
    .acc_valid (port_acc_valid),
    .acc_port  (port_acc_sel),
    .port_en   (port_en),
    .acc_fault (acc_fault)
  );

  // Registered outputs; enable follows the selected bit one cycle later
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_clk_en    <= 8'h00;
      port_bus_fault <= 1'b0;
    end else begin
      port_clk_en    <= port_en;   // [RULE1]
      port_bus_fault <= acc_fault; // [RULE2]
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------------
  wire aw_hs   = s_axi_awvalid & s_axi_awready;
  wire w_hs    = s_axi_wvalid & s_axi_wready;
  wire aw_now  = have_aw_ff | aw_hs;
  wire w_now   = have_w_ff | w_hs;
  wire [11:0] wa = have_aw_ff ? waddr_ff : s_axi_awaddr;
  wire [31:0] wd = have_w_ff ? wdata_ff : s_axi_wdata;
  wire [3:0]  ws = have_w_ff ? wstrb_ff : s_axi_wstrb;
  wire wr_go   = aw_now & w_now & ~s_axi_bvalid;
  wire wr_hit  = (wa[11:2] == GATE_ADDR[11:2]);
  wire wr_stat = (wa[11:2] == STAT_ADDR[11:2]);

  // Address and data accepted in either order; one write in flight
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_ff       <= GATE_RST[7:0];  // [RULE3]
      waddr_ff      <= 12'h000;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      have_aw_ff    <= 1'b0;
      have_w_ff     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      if (aw_hs) begin
        waddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        have_aw_ff   <= 1'b0;
        have_w_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Only the low byte holds state; upper bits are dropped
        if (wr_hit && ws[0]) begin
          gate_ff <= wd[7:0] & GATE_WMASK[7:0]; // [RULE4] [RULE5]
        end
        s_axi_bresp <= (wr_hit || wr_stat) ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        have_aw_ff <= aw_now;
        have_w_ff  <= w_now;
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      // Ready one cycle after reset, dropped while a channel holds its item
      s_axi_awready <= ~(aw_now & ~wr_go) & ~(s_axi_awready & s_axi_awvalid & ~w_now);
      s_axi_wready  <= ~(w_now & ~wr_go) & ~(s_axi_wready & s_axi_wvalid & ~aw_now);
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------------
  wire ar_hs   = s_axi_arvalid & s_axi_arready;
  wire rd_hit  = (s_axi_araddr[11:2] == GATE_ADDR[11:2]);
  wire rd_stat = (s_axi_araddr[11:2] == STAT_ADDR[11:2]);

  // Status word: run enables, deep enables, auto gating, mode
  wire [31:0] stat_word = {13'h0000, power_mode, auto_clock_gating_enable,
                           deep_sleep_port_clock_gate, run_port_clock_gate};

  // Single read in flight; arready falls while the answer waits
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        if (rd_hit) begin
          s_axi_rdata <= {24'h00_0000, gate_ff}; // [RULE5]
          s_axi_rresp <= `RESP_OKAY;
        end else if (rd_stat) begin
          s_axi_rdata <= stat_word;
          s_axi_rresp <= `RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// ### sleep_gate_map.vh
// Register offsets, field positions, reset values and mode codes of the sleep port gate
`ifndef SLEEP_GATE_MAP_VH
`define SLEEP_GATE_MAP_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SPCG_OFFSET      12'h0118
`define SPCG_RESET       32'h0000_0000
`define SPCG_WMASK       32'h0000_00ff
`define SPCG_PORTS       8
`define SPCG_PORT_A      0
`define SPCG_PORT_H      7
// Bus-visible mirrors of the run/deep-sleep enables, auto-gating and power mode
`define SPCG_STAT_OFFSET 12'h011c

// ----------------------------------------------------------------------------
// Power modes
// ----------------------------------------------------------------------------
`define MODE_RUN         2'b00
`define MODE_SLEEP       2'b01
`define MODE_DEEP        2'b10

// ----------------------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------------------
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// ### port_gate_sel.v
// Per-port clock enable selection across run, sleep and deep-sleep modes
`timescale 1ns/100ps
module port_gate_sel (
  // Mode inputs
  input  wire [1:0] power_mode,
  input  wire       auto_clock_gating_enable,
  // Enable sources
  input  wire [7:0] run_port_clock_gate,
  input  wire [7:0] sleep_port_clock_gate,
  input  wire [7:0] deep_sleep_port_clock_gate,
  // Selected enables
  output wire [7:0] port_en
);
`include "sleep_gate_map.vh"

  // One selector per port; sleep/deep registers only matter with auto gating on
  genvar i;
  generate
    for (i = 0; i < `SPCG_PORTS; i = i + 1) begin : g_port
      assign port_en[i] =
        !auto_clock_gating_enable ? run_port_clock_gate[i] :                // [RULE9]
        (power_mode == `MODE_SLEEP) ? sleep_port_clock_gate[i] :            // [RULE6] [RULE7]
        (power_mode == `MODE_DEEP)  ? deep_sleep_port_clock_gate[i] :
                                      run_port_clock_gate[i];
    end
  endgenerate
endmodule

// ### port_fault_chk.v
// Bus fault detection for accesses aimed at an unclocked port
`timescale 1ns/100ps
module port_fault_chk (
  // Access request
  input  wire       acc_valid,
  input  wire [2:0] acc_port,
  // Current port enables
  input  wire [7:0] port_en,
  // Result
  output wire       acc_fault
);
  // A gated port cannot answer, so any access to it faults
  assign acc_fault = acc_valid & ~port_en[acc_port]; // [RULE2]
endmodule

// ### sleep_gate_properties.sv
// Port-level assertions for the sleep port clock gate
`timescale 1ns/100ps
`include "sleep_gate_map.vh"
module sleep_gate_properties (
  // Clock and reset
  input wire        sys_clk,
  input wire        arst_n,
  // Bus handshakes
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // Modes and gating
  input wire [1:0]  power_mode,
  input wire        auto_clock_gating_enable,
  input wire [7:0]  run_port_clock_gate,
  input wire [7:0]  deep_sleep_port_clock_gate,
  input wire [7:0]  port_clk_en,
  input wire        port_acc_valid,
  input wire [2:0]  port_acc_sel,
  input wire        port_bus_fault
);
  reg [11:0] rd_addr_ff;
  reg        wr_seen_ff;
  // Track read address and whether a write finished since reset
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_addr_ff <= 12'h000;
      wr_seen_ff <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready)
        rd_addr_ff <= s_axi_araddr;
      if (s_axi_bvalid && s_axi_bready)
        wr_seen_ff <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_run;
    power_mode == `MODE_RUN |=> port_clk_en == $past(run_port_clock_gate);
  endproperty
  a_run: assert property (p_run) else $error("run enables not used");
  property p_deep;
    auto_clock_gating_enable && power_mode == `MODE_DEEP
      |=> port_clk_en == $past(deep_sleep_port_clock_gate);
  endproperty
  a_deep: assert property (p_deep) else $error("deep enables not used");
  property p_noauto;
    !auto_clock_gating_enable |=> port_clk_en == $past(run_port_clock_gate);
  endproperty
  a_noauto: assert property (p_noauto) else $error("run enables not kept");
  property p_sleep;
    $rose(s_axi_rvalid) && rd_addr_ff == `SPCG_OFFSET
      && $past(auto_clock_gating_enable && power_mode == `MODE_SLEEP)
      |-> port_clk_en == s_axi_rdata[7:0];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep enables differ");
  property p_rst;
    $rose(s_axi_rvalid) && rd_addr_ff == `SPCG_OFFSET && !wr_seen_ff
      |-> s_axi_rdata == `SPCG_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_upper;
    s_axi_rvalid && rd_addr_ff == `SPCG_OFFSET |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits not zero");
  property p_fault;
    port_acc_valid && !auto_clock_gating_enable && $past(!auto_clock_gating_enable)
      && $stable(run_port_clock_gate) && $past(arst_n)
      |=> port_bus_fault == !$past(run_port_clock_gate[port_acc_sel]);
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag wrong");
  property p_map;
    port_acc_valid && auto_clock_gating_enable && power_mode == `MODE_DEEP
      && $past(auto_clock_gating_enable) && $stable(power_mode)
      && $stable(deep_sleep_port_clock_gate) && $past(arst_n)
      |=> port_bus_fault == !$past(deep_sleep_port_clock_gate[port_acc_sel]);
  endproperty
  a_map: assert property (p_map) else $error("port index mapping wrong");
endmodule

// ### core_bus_model.sv
// Bus master model standing for the processor core
`timescale 1ns/100ps
module core_bus_model (
  // Clock
  input wire        sys_clk,
  // Write side
  output reg [11:0] s_axi_awaddr = 12'h000,
  output reg        s_axi_awvalid = 1'b0,
  input wire        s_axi_awready,
  output reg [31:0] s_axi_wdata = 32'h0000_0000,
  output reg [3:0]  s_axi_wstrb = 4'h0,
  output reg        s_axi_wvalid = 1'b0,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  output reg        s_axi_bready = 1'b0,
  // Read side
  output reg [11:0] s_axi_araddr = 12'h000,
  output reg        s_axi_arvalid = 1'b0,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  output reg        s_axi_rready = 1'b0
);
  // One write; released items show inverted payload so nothing stale passes
  task automatic wr(input [11:0] a, input [31:0] d, output [1:0] r);
    bit aw_done = 0;
    bit w_done = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  // One read; rready held until the data is seen
  task automatic rd(input [11:0] a, output [31:0] d, output [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule

// ### sleep_port_clock_gate_tb.sv
// Self-checking bench for the sleep port clock gate
`timescale 1ns/100ps
`include "sleep_gate_map.vh"
module sleep_port_clock_gate_tb;
  reg        sys_clk = 0;
  reg        arst_n = 0;
  reg [1:0]  power_mode = 0;
  reg        auto_clock_gating_enable = 0;
  reg [7:0]  run_port_clock_gate = 0;
  reg [7:0]  deep_sleep_port_clock_gate = 0;
  reg        port_acc_valid = 0;
  reg [2:0]  port_acc_sel = 0;
  wire [11:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0]  s_axi_wstrb;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [7:0]  port_clk_en;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire port_bus_fault;
  integer err_total = 0;
  integer checks = 0;
  integer seed = 3;
  integer i;
  reg [31:0] d, q;
  reg [1:0]  r;
  reg [7:0]  sreg = 0;
  sleep_port_clock_gate sleep_port_clock_gate_inst (.*);
  core_bus_model core_bus_model_inst (.*);
  // 25 MHz clock
  initial forever #20 sys_clk = ~sys_clk;
  // Compare and count
  task chk(input string n, input [31:0] e, input [31:0] s);
    checks = checks + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Enables the selection should give now
  function [7:0] exp_en(input [1:0] m, input a);
    if (a && m == `MODE_SLEEP)
      exp_en = sreg;
    else if (a && m == `MODE_DEEP)
      exp_en = deep_sleep_port_clock_gate;
    else
      exp_en = run_port_clock_gate;
  endfunction
  // Random sibling enables, one port access, outputs checked once settled
  task drive(input [1:0] m, input a, input [2:0] p, input v);
    reg [7:0] e;
    @(posedge sys_clk);
    power_mode <= m;
    auto_clock_gating_enable <= a;
    run_port_clock_gate <= $random(seed);
    deep_sleep_port_clock_gate <= $random(seed);
    port_acc_valid <= v;
    port_acc_sel <= p;
    repeat (2) @(posedge sys_clk);
    #1;
    e = exp_en(m, a);
    chk("port_clk_en", {24'h00_0000, e}, {24'h00_0000, port_clk_en});
    chk("port_bus_fault", {31'h0, v & !e[p]}, {31'h0, port_bus_fault});
  endtask
  task test_done;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #2000000;
    err_total = err_total + 1;
    test_done;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    core_bus_model_inst.rd(`SPCG_OFFSET, q, r);
    chk("reset value", `SPCG_RESET, q);
    drive(`MODE_SLEEP, 1'b1, 3'd5, 1'b1);
    for (i = 0; i < 8; i = i + 1) begin
      core_bus_model_inst.wr(`SPCG_OFFSET, 32'h0000_0001 << i, r);
      sreg = 8'h01 << i;
      drive(`MODE_SLEEP, 1'b1, i, 1'b1);
      drive(`MODE_SLEEP, 1'b1, i + 1, 1'b1);
    end
    for (i = 0; i < 40; i = i + 1) begin
      d = $random(seed);
      core_bus_model_inst.wr(`SPCG_OFFSET, d, r);
      sreg = d[7:0];
      chk("write resp", `RESP_OKAY, r);
      core_bus_model_inst.rd(`SPCG_OFFSET, q, r);
      chk("read back", {24'h00_0000, sreg}, q);
      drive(d[9:8], d[10], d[13:11], d[14]);
    end
    core_bus_model_inst.rd(`SPCG_STAT_OFFSET, q, r);
    chk("status", {13'h0, power_mode, auto_clock_gating_enable,
                   deep_sleep_port_clock_gate, run_port_clock_gate}, q);
    chk("status resp", `RESP_OKAY, r);
    core_bus_model_inst.wr(12'h200, 32'hffff_ffff, r);
    chk("unmapped write", `RESP_SLVERR, r);
    core_bus_model_inst.rd(12'h200, q, r);
    chk("unmapped read", `RESP_SLVERR, r);
    chk("unmapped data", 32'h0000_0000, q);
    core_bus_model_inst.rd(`SPCG_OFFSET, q, r);
    chk("unchanged", {24'h00_0000, sreg}, q);
    core_bus_model_inst.wr(`SPCG_OFFSET, q | 32'h0000_0080, r);
    core_bus_model_inst.rd(`SPCG_OFFSET, d, r);
    chk("read-modify-write", q | 32'h0000_0080, d);
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    core_bus_model_inst.rd(`SPCG_OFFSET, q, r);
    chk("value after second reset", `SPCG_RESET, q);
    test_done;
  end
endmodule
bind sleep_port_clock_gate sleep_gate_properties sleep_gate_properties_inst (
  .sys_clk, .arst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .power_mode, .auto_clock_gating_enable,
  .run_port_clock_gate, .deep_sleep_port_clock_gate, .port_clk_en, .port_acc_valid,
  .port_acc_sel, .port_bus_fault);
